// *** src/phy_basic_control_register.sv ***
// Basic control register at management address zero of a 10/100 transceiver
`timescale 1ns/100ps

module phy_basic_control_register (
    // Clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    // Strap pins
    input  wire logic        i_speed_strap_pin,
    input  wire logic        i_autoneg_strap_pin,
    input  wire logic        i_isolate_strap_pin,
    input  wire logic        i_full_duplex_strap_pin,
    // Management register port
    input  wire logic        i_mgmt_wr,
    input  wire logic        i_mgmt_rd,
    input  wire logic [4:0]  i_mgmt_addr,
    input  wire logic [15:0] i_mgmt_wdata,
    output logic      [15:0] o_mgmt_rdata,
    output logic             o_mgmt_rvalid,
    // Core controls
    input  wire logic        i_aneg_restart_taken,
    input  wire logic        i_aneg_speed_100,
    input  wire logic        i_aneg_full_duplex,
    output logic             o_chip_reset,
    output logic             o_speed_100,
    output logic             o_full_duplex,
    output logic             o_aneg_enable,
    output logic             o_aneg_restart,
    output logic             o_power_down,
    output logic             o_pd_wake_busy,
    output logic             o_isolate,
    output logic             o_line_disconnect,
    output logic             o_loop_100,
    output logic             o_loop_10,
    output logic             o_col_test
);

    // ****************************************
    // Strap synchronisers and capture
    // ****************************************
    logic [3:0]  strap_meta_r;
    logic [3:0]  strap_sync_r;
    logic [1:0]  init_cnt_r;
    logic        init_done_r;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] strap_val;
    logic [2:0]  rst_cnt_r;
    logic [7:0]  pd_cnt_r;

    always_ff @(posedge i_clock) begin
        strap_meta_r <= {i_speed_strap_pin, i_autoneg_strap_pin,
                         i_isolate_strap_pin, i_full_duplex_strap_pin};
        strap_sync_r <= strap_meta_r;
    end

    wire s_speed  = strap_sync_r[3];
    wire s_aneg   = strap_sync_r[2];
    wire s_iso    = strap_sync_r[1];
    wire s_fdx    = strap_sync_r[0];

    // Default word built from the straps
    always_comb begin
        strap_val                             = phy_ctrl_pkg::CTRL_RESET_BASE;
        strap_val[phy_ctrl_pkg::BIT_SPEED]    = s_speed;
        strap_val[phy_ctrl_pkg::BIT_ANEG_EN]  = s_aneg;
        strap_val[phy_ctrl_pkg::BIT_ISOLATE]  = s_iso;
        strap_val[phy_ctrl_pkg::BIT_ANEG_RST] = s_aneg & s_speed;
        strap_val[phy_ctrl_pkg::BIT_DUPLEX]   = s_fdx;
    end

    // ****************************************
    // Register write logic
    // ****************************************
    wire hit_wr      = i_mgmt_wr && (i_mgmt_addr == phy_ctrl_pkg::CTRL_ADDR);
    wire rst_req     = hit_wr && i_mgmt_wdata[phy_ctrl_pkg::BIT_RESET];
    wire rst_active  = (rst_cnt_r != 3'h0);
    wire pd_cleared  = ctrl_r[phy_ctrl_pkg::BIT_PWR_DOWN] && hit_wr
                       && !i_mgmt_wdata[phy_ctrl_pkg::BIT_PWR_DOWN];
    wire rst_restart = ctrl_r[phy_ctrl_pkg::BIT_ANEG_RST] && i_aneg_restart_taken;

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (hit_wr) begin
            ctrl_nxt = i_mgmt_wdata & phy_ctrl_pkg::CTRL_WR_MASK;
            ctrl_nxt[phy_ctrl_pkg::BIT_RESET] = 1'b0;
            ctrl_nxt[phy_ctrl_pkg::BIT_ANEG_RST] =
                i_mgmt_wdata[phy_ctrl_pkg::BIT_ANEG_RST] | ctrl_r[phy_ctrl_pkg::BIT_ANEG_RST];
        end
        if (rst_restart && !(hit_wr && i_mgmt_wdata[phy_ctrl_pkg::BIT_ANEG_RST])) begin
            ctrl_nxt[phy_ctrl_pkg::BIT_ANEG_RST] = 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            init_cnt_r  <= 2'h0;
            init_done_r <= 1'b0;
            ctrl_r      <= phy_ctrl_pkg::CTRL_RESET_BASE;
        end else if (!init_done_r || rst_active) begin
            init_cnt_r  <= init_cnt_r + 2'h1;
            init_done_r <= (init_cnt_r == 2'h3);
            ctrl_r      <= strap_val;
        end else begin
            ctrl_r      <= ctrl_nxt;
        end
    end

    // Chip reset pulse counter
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rst_cnt_r <= 3'h0;
        end else if (rst_req && init_done_r && !rst_active) begin
            rst_cnt_r <= 3'(phy_ctrl_pkg::CHIP_RST_CYCLES);
        end else if (rst_active) begin
            rst_cnt_r <= rst_cnt_r - 3'h1;
        end
    end

    // Power-down wake window during which writes are not safe
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            pd_cnt_r <= 8'h00;
        end else if (pd_cleared && init_done_r && !rst_active) begin
            pd_cnt_r <= 8'(phy_ctrl_pkg::PD_WAKE_CYCLES);
        end else if (pd_cnt_r != 8'h00) begin
            pd_cnt_r <= pd_cnt_r - 8'h01;
        end
    end

    // ****************************************
    // Derived controls and readback
    // ****************************************
    wire aneg      = ctrl_r[phy_ctrl_pkg::BIT_ANEG_EN];
    wire loop      = ctrl_r[phy_ctrl_pkg::BIT_LOOPBACK];
    wire spd_nxt   = aneg ? i_aneg_speed_100 : ctrl_r[phy_ctrl_pkg::BIT_SPEED];
    wire fdx_nxt   = aneg ? i_aneg_full_duplex : ctrl_r[phy_ctrl_pkg::BIT_DUPLEX];
    wire hit_rd    = i_mgmt_rd && (i_mgmt_addr == phy_ctrl_pkg::CTRL_ADDR);

    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            o_chip_reset      <= 1'b0;
            o_speed_100       <= 1'b0;
            o_full_duplex     <= 1'b0;
            o_aneg_enable     <= 1'b0;
            o_aneg_restart    <= 1'b0;
            o_power_down      <= 1'b0;
            o_pd_wake_busy    <= 1'b0;
            o_isolate         <= 1'b0;
            o_line_disconnect <= 1'b0;
            o_loop_100        <= 1'b0;
            o_loop_10         <= 1'b0;
            o_col_test        <= 1'b0;
            o_mgmt_rdata      <= 16'h0000;
            o_mgmt_rvalid     <= 1'b0;
        end else begin
            o_chip_reset      <= rst_active;
            o_speed_100       <= spd_nxt;
            o_full_duplex     <= fdx_nxt;
            o_aneg_enable     <= aneg;
            o_aneg_restart    <= aneg && ctrl_r[phy_ctrl_pkg::BIT_ANEG_RST];
            o_power_down      <= ctrl_r[phy_ctrl_pkg::BIT_PWR_DOWN];
            o_pd_wake_busy    <= (pd_cnt_r != 8'h00);
            o_isolate         <= ctrl_r[phy_ctrl_pkg::BIT_ISOLATE];
            o_line_disconnect <= loop && spd_nxt;
            o_loop_100        <= loop && spd_nxt;
            o_loop_10         <= loop && !spd_nxt;
            o_col_test        <= loop && ctrl_r[phy_ctrl_pkg::BIT_COL_TEST];
            o_mgmt_rdata      <= hit_rd ? ctrl_r : 16'h0000;
            o_mgmt_rvalid     <= i_mgmt_rd;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    reset_self_clear_a: assert property (init_done_r && !rst_active && rst_req |=>
        rst_active ##1 rst_active[*3] ##1 !rst_active) else $error("chip reset pulse wrong");
    loop_fast_a: assert property (loop && spd_nxt |=> o_line_disconnect && o_loop_100)
        else $error("100M loopback not applied");
    loop_slow_a: assert property (loop && !spd_nxt |=> o_loop_10 && !o_loop_100)
        else $error("10M loopback not applied");
    speed_manual_a: assert property (!aneg |=>
        o_speed_100 == $past(ctrl_r[phy_ctrl_pkg::BIT_SPEED]))
        else $error("manual speed not followed");
    aneg_override_a: assert property (aneg |=> o_full_duplex == $past(i_aneg_full_duplex))
        else $error("negotiation does not override duplex");
    restart_clear_a: assert property (init_done_r && !rst_active && rst_restart && !hit_wr
        |=> !ctrl_r[phy_ctrl_pkg::BIT_ANEG_RST]) else $error("restart bit not self cleared");
    col_gate_a: assert property (!loop |=> !o_col_test)
        else $error("collision test without loopback");
    ro_zero_a: assert property (!ctrl_r[phy_ctrl_pkg::BIT_RESET] &&
        (ctrl_r & ~phy_ctrl_pkg::CTRL_WR_MASK) == 16'h0000)
        else $error("read-only bits not zero");
    pd_keep_a: assert property (init_done_r && !rst_active && !hit_wr && !rst_restart
        |=> $stable(ctrl_r)) else $error("configuration changed unprompted");
    strap_load_a: assert property (rst_active |=> aneg == $past(s_aneg))
        else $error("strap default not loaded");

    reset_cov_c: cover property (rst_req ##1 rst_active);
    loop_cov_c: cover property (o_loop_100 ##[1:20] o_loop_10);
    col_cov_c: cover property (o_col_test);
    pd_cov_c: cover property (pd_cleared ##1 pd_cnt_r != 8'h00);

endmodule : phy_basic_control_register

// *** src/phy_ctrl_pkg.sv ***
// Package with address, field positions, reset values and timing of the basic control register
package phy_ctrl_pkg;
    localparam logic [4:0]  CTRL_ADDR       = 5'h00;
    localparam int          BIT_RESET       = 15;
    localparam int          BIT_LOOPBACK    = 14;
    localparam int          BIT_SPEED       = 13;
    localparam int          BIT_ANEG_EN     = 12;
    localparam int          BIT_PWR_DOWN    = 11;
    localparam int          BIT_ISOLATE     = 10;
    localparam int          BIT_ANEG_RST    = 9;
    localparam int          BIT_DUPLEX      = 8;
    localparam int          BIT_COL_TEST    = 7;
    localparam logic [15:0] CTRL_WR_MASK    = 16'hFF83;
    localparam logic [15:0] CTRL_RESET_BASE = 16'h0000;
    localparam int          CLK_PERIOD_PS   = 5000;
    localparam int          PD_WAKE_NS      = 500;
    localparam int          PD_WAKE_CYCLES  = (PD_WAKE_NS * 1000 + CLK_PERIOD_PS - 1)
                                              / CLK_PERIOD_PS;
    localparam int          CHIP_RST_CYCLES = 4;
endpackage : phy_ctrl_pkg

// *** tb/mgmt_restart_partner.sv ***
// Negotiation engine stand-in that accepts restart requests
`timescale 1ns/100ps
module mgmt_restart_partner (
    // Clock and reset
    input  wire logic i_clock,
    input  wire logic i_rst,
    // Control
    input  wire logic i_enable,
    input  wire logic i_restart,
    output logic      o_taken
);
    logic [1:0] wait_r;
    // Restart taken four cycles after request
    always_ff @(posedge i_clock) begin
        o_taken <= 1'b0;
        if (i_rst || !i_enable || !i_restart) wait_r <= 2'h0;
        else if (wait_r == 2'h3) begin
            o_taken <= 1'b1;
            wait_r  <= 2'h0;
        end else wait_r <= wait_r + 2'h1;
    end
endmodule : mgmt_restart_partner

// *** tb/tb_phy_basic_control_register.sv ***
// Self-checking bench for the basic control register
`timescale 1ns/100ps
module tb_phy_basic_control_register;
    logic i_clock = 0, i_rst = 1, s_sp = 0, s_an = 0, s_is = 0, s_fd = 0, wr = 0, rd = 0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wd = 16'h0000, rdat, ref_r, tbl [4];
    logic rv, taken, pen = 0, nsp = 0, nfd = 0;
    logic crst, sp, fd, ae, ar, pd, busy, iso, ld, l1, l0, ct;
    int errors = 0, checked = 0, cyc = 0, n;
    always #2.5 i_clock = ~i_clock;
    phy_basic_control_register phy_basic_control_register_inst (.i_clock(i_clock),
        .i_rst(i_rst), .i_speed_strap_pin(s_sp), .i_autoneg_strap_pin(s_an),
        .i_isolate_strap_pin(s_is), .i_full_duplex_strap_pin(s_fd), .i_mgmt_wr(wr),
        .i_mgmt_rd(rd), .i_mgmt_addr(addr), .i_mgmt_wdata(wd), .o_mgmt_rdata(rdat),
        .o_mgmt_rvalid(rv), .i_aneg_restart_taken(taken), .i_aneg_speed_100(nsp),
        .i_aneg_full_duplex(nfd), .o_chip_reset(crst), .o_speed_100(sp), .o_full_duplex(fd),
        .o_aneg_enable(ae), .o_aneg_restart(ar), .o_power_down(pd), .o_pd_wake_busy(busy),
        .o_isolate(iso), .o_line_disconnect(ld), .o_loop_100(l1), .o_loop_10(l0),
        .o_col_test(ct));
    mgmt_restart_partner mgmt_restart_partner_inst (.i_clock(i_clock), .i_rst(i_rst),
        .i_enable(pen), .i_restart(ar), .o_taken(taken));
    // ****************************************
    // Model and compares
    // ****************************************
    function automatic logic [15:0] dflt();
        return {2'h0, s_sp, s_an, 1'b0, s_is, s_sp & s_an, s_fd, 8'h00};
    endfunction : dflt
    task automatic chk_rd(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected read at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_rd
    task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("unexpected output at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_out
    task automatic do_wr(input logic [4:0] a, input logic [15:0] d);
        // Host keeps clear of the wake window after power-down
        while (busy) @(posedge i_clock);
        @(posedge i_clock) begin
            wr <= 1'b1; addr <= a; wd <= d;
        end
        @(posedge i_clock) wr <= 1'b0;
        if (a == 5'h00) ref_r = d[15] ? dflt()
            : ((d & 16'h7D83) | (ref_r & 16'h0200) | (d & 16'h0200));
    endtask : do_wr
    task automatic do_rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge i_clock) begin
            rd <= 1'b1; addr <= a;
        end
        @(posedge i_clock) rd <= 1'b0;
        #1 chk_rd({15'h0000, rv}, 16'h0001);
        chk_rd(rdat, exp);
    endtask : do_rd
    task automatic chk_ctl();
        logic s, f, l;
        logic [15:0] g, e;
        s = ref_r[12] ? nsp : ref_r[13];
        f = ref_r[12] ? nfd : ref_r[8];
        l = ref_r[14];
        e = {6'h00, s, f, ref_r[12], ref_r[12] & ref_r[9], ref_r[11], ref_r[10],
             l & s, l & s, l & !s, l & ref_r[7]};
        repeat (2) @(posedge i_clock);
        #1 g = {6'h00, sp, fd, ae, ar, pd, iso, ld, l1, l0, ct};
        chk_out(g, e);
    endtask : chk_ctl
    task automatic cnt_high(input logic sel, output int k);
        k = 0;
        while (!(sel ? crst : busy) && k < 20) @(posedge i_clock) #1 k++;
        k = 0;
        while ((sel ? crst : busy) && k < 300) @(posedge i_clock) #1 k++;
    endtask : cnt_high
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_sim
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        tbl = '{16'h4000, 16'h6100, 16'h4080, 16'h0080};
        void'($urandom(14));
        @(posedge i_clock) {s_sp, s_an, s_is, s_fd} <= 4'($urandom);
        repeat (7) @(posedge i_clock);
        i_rst <= 1'b0;
        repeat (5) @(posedge i_clock);
        ref_r = dflt();
        do_rd(5'h00, ref_r);
        chk_ctl();
        @(posedge i_clock) pen <= 1'b1;
        repeat (10) @(posedge i_clock);
        ref_r[9] = 1'b0;
        do_rd(5'h00, ref_r);
        @(posedge i_clock) pen <= 1'b0;
        do_wr(5'h00, 16'h1200);
        do_rd(5'h00, ref_r);
        chk_ctl();
        @(posedge i_clock) pen <= 1'b1;
        repeat (10) @(posedge i_clock);
        ref_r[9] = 1'b0;
        do_rd(5'h00, ref_r);
        @(posedge i_clock) pen <= 1'b0;
        $display("test restart done");
        for (int i = 0; i < 24; i++) begin
            @(posedge i_clock) {nsp, nfd} <= 2'($urandom);
            do_wr(5'h00, i < 4 ? tbl[i] : 16'($urandom) & 16'h7DFF);
            do_rd(5'h00, ref_r);
            chk_ctl();
        end
        $display("test fields done");
        do_wr(5'h00, 16'h4C01);
        do_wr(5'h00, 16'h4401);
        cnt_high(1'b0, n);
        chk_out(16'(n), 16'(phy_ctrl_pkg::PD_WAKE_CYCLES));
        do_rd(5'h00, 16'h4401);
        chk_ctl();
        do_wr(5'h05, 16'hFFFF);
        do_rd(5'h05, 16'h0000);
        do_rd(5'h00, 16'h4401);
        $display("test power down done");
        @(posedge i_clock) {s_sp, s_an, s_is, s_fd} <= 4'($urandom);
        repeat (3) @(posedge i_clock);
        do_wr(5'h00, 16'h8000);
        cnt_high(1'b1, n);
        chk_out(16'(n), 16'(phy_ctrl_pkg::CHIP_RST_CYCLES));
        repeat (3) @(posedge i_clock);
        do_rd(5'h00, ref_r);
        $display("test chip reset done");
        end_sim();
    end
endmodule : tb_phy_basic_control_register
